// ---- shared/awbp_pkg.sv ----
package awbp_pkg;

    // widths of the external memory port
    localparam int DATA_W  = 16;
    localparam int ADDR_W  = 16;
    localparam int REGIONS = 4;   // chip-select regions 2..5 map to index 0..3

    // per-region and shared asynchronous timing configuration
    typedef struct packed {
        logic                     wait_polarity;
        logic [REGIONS-1:0]       ext_wait_enable;
        logic [7:0]               strobe_extension_limit;
        logic [3:0]               r_setup;
        logic [5:0]               r_strobe;
        logic [2:0]               r_hold;
        logic [3:0]               w_setup;
        logic [5:0]               w_strobe;
        logic [2:0]               w_hold;
        logic [2:0]               turnaround;
    } async_wait_config_t;

    // values after full-chip reset; polarity comes up as 1
    localparam async_wait_config_t CFG_RESET = '{
        wait_polarity:          1'h1,
        ext_wait_enable:        4'h0,
        strobe_extension_limit: 8'h80,
        r_setup:                4'h2,
        r_strobe:               6'h04,
        r_hold:                 3'h1,
        w_setup:                4'h2,
        w_strobe:               6'h04,
        w_hold:                 3'h1,
        turnaround:             3'h2
    };

    // one access request from the on-chip side
    typedef struct packed {
        logic              write;
        logic [1:0]        region;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } req_t;

    // raw interrupt status, also used as the write-one-to-clear strobe
    typedef struct packed {
        logic wait_rise;
        logic timeout_flag;
    } irq_raw_status_t;

    // access sequencer states
    typedef enum logic [2:0] {
        S_INIT,
        S_IDLE,
        S_SETUP,
        S_STROBE,
        S_EXTEND,
        S_HOLD,
        S_TURN
    } fsm_t;

    // length of the initialization sequence after any reset release
    localparam logic [7:0] INIT_CYCLES = 8'h10;
    // smallest phase length in cycles
    localparam logic [7:0] MIN_PHASE   = 8'h01;

endpackage : awbp_pkg

// ---- logic/awbp_sync.sv ----
`timescale 1ns/1ps
// two-flop synchronizer; only the second stage is visible
module awbp_sync #(
    parameter int              W       = 1,
    parameter logic [W-1:0]    RST_VAL = '0
) (
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic [W-1:0]  d_i,
    output logic      [W-1:0]  q_o
);

    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= RST_VAL;
            q_o    <= RST_VAL;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end

endmodule : awbp_sync

// ---- logic/awbp_ext_counter.sv ----
`timescale 1ns/1ps
// strobe extension budget; reloaded per access, counts down while stretching
module awbp_ext_counter (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       clr_i,
    input  wire logic       load_i,
    input  wire logic [7:0] limit_i,
    input  wire logic       dec_i,
    output logic            expired_o
);

    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    // load beats decrement; decrement stops at zero
    always_comb begin
        cnt_d = cnt_q;
        if (clr_i) begin
            cnt_d = 8'h00;
        end else if (load_i) begin
            cnt_d = limit_i;
        end else if (dec_i && (cnt_q != 8'h00)) begin
            cnt_d = cnt_q - 8'h01;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign expired_o = (cnt_q == 8'h00);

endmodule : awbp_ext_counter

// ---- logic/async_wait_bus_park.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - in NAND mode the status output shows the wait pin level three cycles late
// - each rising edge of the wait pin sets the wait-rise raw flag
// - wait polarity never alters NAND status or the wait-rise flag
// - regions 2 to 5 each own an extended-wait enable bit
// - while wait is active add strobe cycles, then resume at last strobe cycle
// - a programmable limit caps the strobe extension in clock cycles
// - on limit expiry go to hold regardless of the wait level
// - limit expiry raises an asynchronous-timeout event
// - wait polarity resets to 1; 1 waits on high, 0 waits on low
// - when idle, drive the data bus with the last written value
// - reads release the data bus when chip select asserts
// - after a read, park again once turnaround ends
// - a read during self-refresh leaves the bus tri-stated afterwards
// - chip reset clears everything; module reset clears only the sequencer
// - reset release starts initialization and drops any pending request
// - chip reset is the device reset; module reset is the sleep controller's
// - wait-rise flag tells software the NAND device is ready again
// - timeout is flagged only in extended-wait mode on overlong wait
module async_wait_bus_park (
    // clock and resets
    input  wire logic                         SYS_CLK_I,
    input  wire logic                         SYS_RST_I,
    input  wire logic                         SM_ONLY_RESET_N_I,
    // configuration and mode
    input  wire logic                         CFG_WE_I,
    input  wire awbp_pkg::async_wait_config_t CFG_I,
    output awbp_pkg::async_wait_config_t      CFG_O,
    input  wire logic                         NAND_MODE_I,
    input  wire logic                         SELF_REFRESH_I,
    // status and events
    output logic                              NAND_STATUS_REG_O,
    output awbp_pkg::irq_raw_status_t         IRQ_RAW_STATUS_O,
    input  wire awbp_pkg::irq_raw_status_t    IRQ_CLEAR_I,
    output logic                              WAIT_RISE_EVENT_O,
    output logic                              ASYNC_TIMEOUT_EVENT_O,
    // access requests
    input  wire logic                         REQ_VALID_I,
    input  wire awbp_pkg::req_t               REQ_I,
    output logic                              REQ_READY_O,
    output logic                              RD_VALID_O,
    output logic [awbp_pkg::DATA_W-1:0]       RD_DATA_O,
    // external memory pins
    input  wire logic                         EXT_WAIT_INPUT_I,
    output logic [awbp_pkg::REGIONS-1:0]      MEM_CHIP_SELECT_N_O,
    output logic                              MEM_OE_N_O,
    output logic                              MEM_WE_N_O,
    output logic [awbp_pkg::ADDR_W-1:0]       MEM_ADDR_O,
    input  wire logic [awbp_pkg::DATA_W-1:0]  MEM_DATA_I,
    output logic [awbp_pkg::DATA_W-1:0]       MEM_DATA_O,
    output logic                              MEM_DATA_OE_O
);

    // module state in one record; synchronizers and extension counter sit outside it
    typedef struct packed {
        awbp_pkg::async_wait_config_t cfg;
        awbp_pkg::irq_raw_status_t    irq;
        logic                         wait_prev;
        logic                         nand_status;
        logic                         rise_evt;
        logic                         timeout_evt;
        awbp_pkg::fsm_t               fsm;
        logic [7:0]                   cnt;
        awbp_pkg::req_t               req;
        logic                         sr_read;
        logic                         ext_done;
        logic                         floating;
        logic [awbp_pkg::DATA_W-1:0]  park;
        logic [awbp_pkg::DATA_W-1:0]  rdata;
        logic                         rd_valid;
        logic                         ready;
        logic [awbp_pkg::REGIONS-1:0] cs_n;
        logic                         oe_n;
        logic                         we_n;
        logic                         data_oe;
        logic [awbp_pkg::DATA_W-1:0]  data_o;
    } state_t;

    localparam state_t ST_RESET = '{
        cfg:         awbp_pkg::CFG_RESET,
        irq:         '{wait_rise: 1'h0, timeout_flag: 1'h0},
        wait_prev:   1'h0,
        nand_status: 1'h0,
        rise_evt:    1'h0,
        timeout_evt: 1'h0,
        fsm:         awbp_pkg::S_INIT,
        cnt:         8'h00,
        req:         '0,
        sr_read:     1'h0,
        ext_done:    1'h0,
        floating:    1'h0,
        park:        16'h0000,
        rdata:       16'h0000,
        rd_valid:    1'h0,
        ready:       1'h0,
        cs_n:        4'hF,
        oe_n:        1'h1,
        we_n:        1'h1,
        data_oe:     1'h1,
        data_o:      16'h0000
    };

    state_t                      q;
    state_t                      n;
    logic                        wait_s;
    logic                        mrst_n_s;
    logic [awbp_pkg::DATA_W-1:0] data_s;
    logic                        ext_expired;
    logic                        ext_load;
    logic                        ext_dec;
    logic                        wait_active;
    logic                        wait_rise;
    logic                        go_hold;
    logic                        set_timeout;
    logic                        mrst;

    // phase lengths of zero are stretched to one cycle
    function automatic logic [7:0] phase_len(input logic [7:0] v);
        phase_len = (v == 8'h00) ? awbp_pkg::MIN_PHASE : v;
    endfunction : phase_len

    // pin and module-reset synchronizers
    awbp_sync #(.W(1), .RST_VAL(1'h0)) u_wait_sync (
        .clk_i (SYS_CLK_I),
        .rst_i (SYS_RST_I),
        .d_i   (EXT_WAIT_INPUT_I),
        .q_o   (wait_s)
    );

    // module reset reads asserted until two clean samples
    awbp_sync #(.W(1), .RST_VAL(1'h0)) u_mrst_sync (
        .clk_i (SYS_CLK_I),
        .rst_i (SYS_RST_I),
        .d_i   (SM_ONLY_RESET_N_I),
        .q_o   (mrst_n_s)
    );

    // read data are sampled two cycles late and captured at the end of the strobe
    awbp_sync #(.W(awbp_pkg::DATA_W), .RST_VAL(16'h0000)) u_data_sync (
        .clk_i (SYS_CLK_I),
        .rst_i (SYS_RST_I),
        .d_i   (MEM_DATA_I),
        .q_o   (data_s)
    );

    awbp_ext_counter u_ext_counter (
        .clk_i     (SYS_CLK_I),
        .rst_i     (SYS_RST_I),
        .clr_i     (mrst),
        .load_i    (ext_load),
        .limit_i   (q.cfg.strobe_extension_limit),
        .dec_i     (ext_dec),
        .expired_o (ext_expired)
    );

    // raw pin view and polarity-adjusted wait view
    assign mrst        = ~mrst_n_s;
    assign wait_rise   = wait_s & ~q.wait_prev;
    assign wait_active = q.cfg.wait_polarity ? wait_s : ~wait_s;

    // next-state logic for the whole module
    always_comb begin
        n           = q;
        n.rd_valid  = 1'h0;
        n.rise_evt  = 1'h0;
        n.timeout_evt = 1'h0;
        ext_load    = 1'h0;
        ext_dec     = 1'h0;
        go_hold     = 1'h0;
        set_timeout = 1'h0;

        // configuration is a register: only chip reset clears it
        if (CFG_WE_I) begin
            n.cfg = CFG_I;
        end

        // raw pin tracking ignores polarity and sequencer state
        n.wait_prev   = wait_s;
        n.nand_status = NAND_MODE_I & wait_s;

        case (q.fsm)
            awbp_pkg::S_INIT: begin
                // bus parked, no strobes during initialization
                n.cs_n    = 4'hF;
                n.data_oe = ~q.floating;
                n.data_o  = q.park;
                if (q.cnt >= awbp_pkg::INIT_CYCLES) begin
                    n.fsm = awbp_pkg::S_IDLE;
                    n.cnt = 8'h00;
                end else begin
                    n.cnt = q.cnt + 8'h01;
                end
            end
            awbp_pkg::S_IDLE: begin
                n.data_oe = ~q.floating;
                n.data_o  = q.park;
                if (REQ_VALID_I && q.ready) begin
                    n.req      = REQ_I;
                    n.ext_done = 1'h0;
                    n.sr_read  = ~REQ_I.write & SELF_REFRESH_I;
                    n.cs_n     = ~(4'h1 << REQ_I.region);
                    n.fsm      = awbp_pkg::S_SETUP;
                    if (REQ_I.write) begin
                        // new write data become the parked value
                        n.park     = REQ_I.wdata;
                        n.floating = 1'h0;
                        n.data_o   = REQ_I.wdata;
                        n.data_oe  = 1'h1;
                        n.cnt      = phase_len({4'h0, q.cfg.w_setup});
                    end else begin
                        n.data_oe  = 1'h0;
                        n.cnt      = phase_len({4'h0, q.cfg.r_setup});
                    end
                end
            end
            awbp_pkg::S_SETUP: begin
                if (q.cnt <= awbp_pkg::MIN_PHASE) begin
                    n.fsm      = awbp_pkg::S_STROBE;
                    n.we_n     = ~q.req.write;
                    n.oe_n     = q.req.write;
                    ext_load   = 1'h1;
                    n.cnt      = q.req.write ? phase_len({2'h0, q.cfg.w_strobe})
                                             : phase_len({2'h0, q.cfg.r_strobe});
                end else begin
                    n.cnt = q.cnt - 8'h01;
                end
            end
            awbp_pkg::S_STROBE: begin
                // only one stretch per access; after it the strobe finishes
                if (q.cfg.ext_wait_enable[q.req.region] && wait_active && !q.ext_done) begin
                    n.fsm = awbp_pkg::S_EXTEND;
                end else if (q.cnt <= awbp_pkg::MIN_PHASE) begin
                    go_hold = 1'h1;
                end else begin
                    n.cnt = q.cnt - 8'h01;
                end
            end
            awbp_pkg::S_EXTEND: begin
                if (!wait_active) begin
                    // back to the final programmed strobe cycle
                    n.fsm      = awbp_pkg::S_STROBE;
                    n.cnt      = awbp_pkg::MIN_PHASE;
                    n.ext_done = 1'h1;
                end else if (ext_expired) begin
                    go_hold     = 1'h1;
                    set_timeout = 1'h1;
                end else begin
                    ext_dec = 1'h1;
                end
            end
            awbp_pkg::S_HOLD: begin
                if (q.cnt <= awbp_pkg::MIN_PHASE) begin
                    n.cs_n = 4'hF;
                    if (q.req.write) begin
                        n.fsm = awbp_pkg::S_IDLE;
                    end else begin
                        n.rd_valid = 1'h1;
                        n.fsm      = awbp_pkg::S_TURN;
                        n.cnt      = phase_len({5'h00, q.cfg.turnaround});
                    end
                end else begin
                    n.cnt = q.cnt - 8'h01;
                end
            end
            awbp_pkg::S_TURN: begin
                if (q.cnt <= awbp_pkg::MIN_PHASE) begin
                    n.fsm      = awbp_pkg::S_IDLE;
                    n.floating = q.sr_read;
                    n.data_oe  = ~q.sr_read;
                    n.data_o   = q.park;
                end else begin
                    n.cnt = q.cnt - 8'h01;
                end
            end
            default: begin
                n.fsm = awbp_pkg::S_INIT;
                n.cnt = 8'h00;
            end
        endcase

        // common end of the strobe: capture read data, drop strobes
        if (go_hold) begin
            n.fsm   = awbp_pkg::S_HOLD;
            n.cnt   = q.req.write ? phase_len({5'h00, q.cfg.w_hold})
                                  : phase_len({5'h00, q.cfg.r_hold});
            n.we_n  = 1'h1;
            n.oe_n  = 1'h1;
            n.rdata = q.req.write ? q.rdata : data_s;
        end

        // sticky raw flags: a new event wins over a same-cycle clear
        n.rise_evt         = wait_rise;
        n.timeout_evt      = set_timeout;
        n.irq.wait_rise    = (q.irq.wait_rise & ~IRQ_CLEAR_I.wait_rise) | wait_rise;
        n.irq.timeout_flag = (q.irq.timeout_flag & ~IRQ_CLEAR_I.timeout_flag) | set_timeout;

        // module reset: sequencer only; config, flags and park value survive
        if (mrst) begin
            n.fsm         = awbp_pkg::S_INIT;
            n.cnt         = 8'h00;
            n.cs_n        = 4'hF;
            n.oe_n        = 1'h1;
            n.we_n        = 1'h1;
            n.rd_valid    = 1'h0;
            n.ext_done    = 1'h0;
            n.timeout_evt = 1'h0;
            n.irq.timeout_flag = q.irq.timeout_flag & ~IRQ_CLEAR_I.timeout_flag;
        end

        // accept requests only from a settled idle state
        n.ready = (n.fsm == awbp_pkg::S_IDLE) && !mrst && !(q.fsm == awbp_pkg::S_IDLE && REQ_VALID_I && q.ready);
    end

    // chip reset clears the whole record
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            q <= ST_RESET;
        end else begin
            q <= n;
        end
    end

    // every output is a flop of the state record
    assign CFG_O                 = q.cfg;
    assign NAND_STATUS_REG_O     = q.nand_status;
    assign IRQ_RAW_STATUS_O      = q.irq;
    assign WAIT_RISE_EVENT_O     = q.rise_evt;
    assign ASYNC_TIMEOUT_EVENT_O = q.timeout_evt;
    assign REQ_READY_O           = q.ready;
    assign RD_VALID_O            = q.rd_valid;
    assign RD_DATA_O             = q.rdata;
    assign MEM_CHIP_SELECT_N_O   = q.cs_n;
    assign MEM_OE_N_O            = q.oe_n;
    assign MEM_WE_N_O            = q.we_n;
    assign MEM_ADDR_O            = q.req.addr;
    assign MEM_DATA_O            = q.data_o;
    assign MEM_DATA_OE_O         = q.data_oe;

endmodule : async_wait_bus_park

// ---- dv/awbp_props.sv ----
`timescale 1ns/1ps
// port-level checks
module awbp_props (
    // clock, resets, config
    input logic                         SYS_CLK_I,
    input logic                         SYS_RST_I,
    input logic                         SM_ONLY_RESET_N_I,
    input awbp_pkg::async_wait_config_t CFG_O,
    // status and events
    input logic                         NAND_MODE_I,
    input logic                         NAND_STATUS_REG_O,
    input awbp_pkg::irq_raw_status_t    IRQ_RAW_STATUS_O,
    input logic                         WAIT_RISE_EVENT_O,
    input logic                         ASYNC_TIMEOUT_EVENT_O,
    // requests and pins
    input logic                         REQ_VALID_I,
    input awbp_pkg::req_t               REQ_I,
    input logic                         REQ_READY_O,
    input logic                         RD_VALID_O,
    input logic                         EXT_WAIT_INPUT_I,
    input logic [3:0]                   MEM_CHIP_SELECT_N_O,
    input logic                         MEM_OE_N_O,
    input logic                         MEM_WE_N_O,
    input logic [15:0]                  MEM_DATA_O,
    input logic                         MEM_DATA_OE_O
);
    // one clock domain
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    // request taken
    sequence take_rd_s; REQ_VALID_I && REQ_READY_O && !REQ_I.write; endsequence
    sequence take_wr_s; REQ_VALID_I && REQ_READY_O && REQ_I.write; endsequence
    // two sync flops and one output flop
    nand_stat_a: assert property (NAND_STATUS_REG_O == ($past(NAND_MODE_I) & $past(EXT_WAIT_INPUT_I, 3)))
        else $error("nand status wrong");
    rise_flag_a: assert property ($rose(EXT_WAIT_INPUT_I) |-> ##[2:4] WAIT_RISE_EVENT_O
        ##[0:1] IRQ_RAW_STATUS_O.wait_rise) else $error("wait rise missed");
    to_hold_a: assert property (ASYNC_TIMEOUT_EVENT_O |-> MEM_OE_N_O && MEM_WE_N_O &&
        (MEM_CHIP_SELECT_N_O != 4'hF)) else $error("timeout not in hold");
    to_flag_a: assert property (ASYNC_TIMEOUT_EVENT_O |-> ##[0:1] IRQ_RAW_STATUS_O.timeout_flag)
        else $error("timeout flag missed");
    ew_only_a: assert property (ASYNC_TIMEOUT_EVENT_O |-> (CFG_O.ext_wait_enable != 4'h0))
        else $error("timeout without ext wait");
    rd_release_a: assert property (take_rd_s |=> !MEM_DATA_OE_O &&
        (MEM_CHIP_SELECT_N_O == ~(4'h1 << $past(REQ_I.region)))) else $error("read select or release wrong");
    wr_drive_a: assert property (take_wr_s |=> MEM_DATA_OE_O && (MEM_DATA_O == $past(REQ_I.wdata)))
        else $error("write data not driven");
    rd_strobe_a: assert property (!MEM_OE_N_O |-> !MEM_DATA_OE_O)
        else $error("bus driven in read strobe");
    rd_done_a: assert property (RD_VALID_O |-> (MEM_CHIP_SELECT_N_O == 4'hF) && !MEM_DATA_OE_O)
        else $error("read end wrong");
    sm_rst_a: assert property (!SM_ONLY_RESET_N_I [*5] |-> (MEM_CHIP_SELECT_N_O == 4'hF) && !REQ_READY_O)
        else $error("module reset ignored");
    pol_rst_a: assert property ($fell(SYS_RST_I) |-> CFG_O.wait_polarity)
        else $error("polarity reset wrong");
    chip_rst_a: assert property (disable iff (1'b0) SYS_RST_I |-> !REQ_READY_O && MEM_DATA_OE_O)
        else $error("chip reset outputs wrong");
endmodule : awbp_props
bind async_wait_bus_park awbp_props i_awbp_props (.*);

// ---- dv/awbp_mem_model.sv ----
`timescale 1ns/1ps
// async memory with a wait pulse from select
module awbp_mem_model (
    input  wire logic        clk_i,
    input  wire logic [3:0]  cs_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic [15:0] addr_i,
    input  wire logic [15:0] data_i,
    input  wire logic        act_high_i,
    input  wire logic [7:0]  busy_len_i,
    input  wire logic        nand_busy_i,
    output logic             wait_o,
    output logic [15:0]      data_o
);
    logic [15:0] mem_q [16];
    logic [7:0]  busy_q = 8'h00;
    logic        sel_q  = 1'b0;
    logic [15:0] last_q = 16'h0000;
    // wait level in the programmed polarity
    assign wait_o = act_high_i ~^ ((busy_q != 8'h00) || nand_busy_i);
    // released bus shows the inverse
    assign data_o = oe_n_i ? ~last_q : mem_q[addr_i[3:0]];
    // wait starts at select
    always @(posedge clk_i) begin
        sel_q <= (cs_n_i != 4'hF);
        if ((cs_n_i != 4'hF) && !sel_q)
            busy_q <= busy_len_i;
        else if (busy_q != 8'h00)
            busy_q <= busy_q - 8'h01;
        if (!we_n_i && (cs_n_i != 4'hF))
            mem_q[addr_i[3:0]] <= data_i;
        if (!oe_n_i)
            last_q <= mem_q[addr_i[3:0]];
    end
endmodule : awbp_mem_model

// ---- dv/tb_async_wait_bus_park.sv ----
`timescale 1ns/1ps
module tb_async_wait_bus_park;
    // design ports
    logic SYS_CLK_I = 1'b0, SYS_RST_I = 1'b0, SM_ONLY_RESET_N_I = 1'b1, CFG_WE_I = 1'b0;
    logic NAND_MODE_I = 1'b0, SELF_REFRESH_I = 1'b0, REQ_VALID_I = 1'b0, EXT_WAIT_INPUT_I;
    logic NAND_STATUS_REG_O, WAIT_RISE_EVENT_O, ASYNC_TIMEOUT_EVENT_O, REQ_READY_O, RD_VALID_O;
    logic MEM_OE_N_O, MEM_WE_N_O, MEM_DATA_OE_O;
    logic [15:0] RD_DATA_O, MEM_ADDR_O, MEM_DATA_I, MEM_DATA_O, mdrv;
    logic [3:0] MEM_CHIP_SELECT_N_O;
    awbp_pkg::async_wait_config_t CFG_I = awbp_pkg::CFG_RESET, CFG_O;
    awbp_pkg::irq_raw_status_t IRQ_RAW_STATUS_O, IRQ_CLEAR_I = '0;
    awbp_pkg::req_t REQ_I = '0;
    logic act_high = 1'b1, nand_busy = 1'b0;
    logic [7:0] busy_len = 8'h00;
    int error_cnt = 0, total_checks = 0, cyc = 0;
    // clock, data wire, timeout
    always #2.5 SYS_CLK_I = ~SYS_CLK_I;
    assign MEM_DATA_I = MEM_DATA_OE_O ? MEM_DATA_O : mdrv;
    always @(posedge SYS_CLK_I) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("[ERR] %0t timeout", $time);
            end_sim();
        end
    end
    async_wait_bus_park i_async_wait_bus_park (.*);
    awbp_mem_model i_awbp_mem_model (.clk_i(SYS_CLK_I), .cs_n_i(MEM_CHIP_SELECT_N_O), .oe_n_i(MEM_OE_N_O),
        .we_n_i(MEM_WE_N_O), .addr_i(MEM_ADDR_O), .data_i(MEM_DATA_O), .act_high_i(act_high),
        .busy_len_i(busy_len), .nand_busy_i(nand_busy), .wait_o(EXT_WAIT_INPUT_I), .data_o(mdrv));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim
    task automatic wait_ready;
        for (int n = 0; n < 200 && REQ_READY_O !== 1'b1; n++)
            @(negedge SYS_CLK_I);
        check(REQ_READY_O, 1);
    endtask : wait_ready
    task automatic set_cfg;
        CFG_WE_I = 1'b1;
        @(negedge SYS_CLK_I);
        CFG_WE_I = 1'b0;
    endtask : set_cfg
    // one access; olen counts strobe cycles
    task automatic access(input logic wr, input logic [1:0] rg, input logic [15:0] a, d, output int olen);
        REQ_I = '{wr, rg, a, d};
        REQ_VALID_I = 1'b1;
        @(negedge SYS_CLK_I);
        REQ_VALID_I = 1'b0;
        olen = 0;
        for (int n = 0; n < 400 && (n < 2 || REQ_READY_O !== 1'b1); n++) begin
            olen += int'((wr ? MEM_WE_N_O : MEM_OE_N_O) === 1'b0);
            @(negedge SYS_CLK_I);
        end
    endtask : access
    // hold chip reset, then wait for ready and check the reset configuration
    task automatic t_reset;
        #1 SYS_RST_I = 1'b1;
        repeat (12) @(negedge SYS_CLK_I);
        SYS_RST_I = 1'b0;
        wait_ready();
        check(CFG_O, awbp_pkg::CFG_RESET);
    endtask : t_reset
    // status follows the pin under both polarities
    task automatic t_nand;
        NAND_MODE_I = 1'b1;
        for (int p = 0; p < 2; p++) begin
            CFG_I.wait_polarity = p[0];
            set_cfg();
            nand_busy = 1'b1;
            repeat (5) @(negedge SYS_CLK_I);
            check(NAND_STATUS_REG_O, 1);
            check(IRQ_RAW_STATUS_O.wait_rise, 1);
            IRQ_CLEAR_I.wait_rise = 1'b1;
            nand_busy = 1'b0;
            @(negedge SYS_CLK_I);
            IRQ_CLEAR_I = '0;
            repeat (4) @(negedge SYS_CLK_I);
            check(NAND_STATUS_REG_O, 0);
            check(IRQ_RAW_STATUS_O.wait_rise, 0);
        end
        NAND_MODE_I = 1'b0;
    endtask : t_nand
    task automatic t_park;
        int n;
        access(1'b1, 2'h1, 16'h0003, 16'hA5C3, n);
        check({MEM_DATA_OE_O, MEM_DATA_O}, 17'h1A5C3);
        access(1'b0, 2'h1, 16'h0003, 16'h0000, n);
        check(RD_DATA_O, 16'hA5C3);
        check(n, 4);
        check({MEM_DATA_OE_O, MEM_DATA_O}, 17'h1A5C3);
    endtask : t_park
    // strobe stretched above 4 cycles in enabled region 2 only; region 3 keeps exactly 4
    task automatic t_ext;
        int n0, n1, n2;
        CFG_I.ext_wait_enable = 4'h4;
        CFG_I.strobe_extension_limit = 8'h0A;
        set_cfg();
        busy_len = 8'h06;
        access(1'b1, 2'h2, 16'h0001, 16'h1111, n0);
        check(n0 > 4, 1);
        check(IRQ_RAW_STATUS_O.timeout_flag, 0);
        busy_len = 8'h28;
        access(1'b1, 2'h3, 16'h0001, 16'h2222, n0);
        check(n0, 4);
        repeat (45) @(negedge SYS_CLK_I);
        access(1'b1, 2'h2, 16'h0001, 16'h3333, n1);
        check(IRQ_RAW_STATUS_O.timeout_flag, 1);
        check(n1 < 16, 1);
        IRQ_CLEAR_I.timeout_flag = 1'b1;
        repeat (45) @(negedge SYS_CLK_I);
        IRQ_CLEAR_I = '0;
        access(1'b1, 2'h2, 16'h0001, 16'h4444, n2);
        check(n2, n1);
        check(IRQ_RAW_STATUS_O.timeout_flag, 1);
        repeat (45) @(negedge SYS_CLK_I);
        act_high = 1'b0;
        CFG_I.wait_polarity = 1'b0;
        set_cfg();
        busy_len = 8'h06;
        access(1'b1, 2'h2, 16'h0001, 16'h5555, n0);
        check(n0 > 4, 1);
    endtask : t_ext
    // a deliberate read in self-refresh
    task automatic t_sr;
        int n;
        SELF_REFRESH_I = 1'b1;
        access(1'b0, 2'h0, 16'h0003, 16'h0000, n);
        SELF_REFRESH_I = 1'b0;
        check(MEM_DATA_OE_O, 0);
        access(1'b1, 2'h0, 16'h0007, 16'h5A3C, n);
        check({MEM_DATA_OE_O, MEM_DATA_O}, 17'h15A3C);
    endtask : t_sr
    // module reset in mid-access
    task automatic t_smrst;
        REQ_I = '{1'b1, 2'h0, 16'h0007, 16'h5A3C};
        REQ_VALID_I = 1'b1;
        @(negedge SYS_CLK_I);
        REQ_VALID_I = 1'b0;
        SM_ONLY_RESET_N_I = 1'b0;
        repeat (6) @(negedge SYS_CLK_I);
        check({MEM_CHIP_SELECT_N_O, REQ_READY_O}, 5'h1E);
        SM_ONLY_RESET_N_I = 1'b1;
        repeat (10) @(negedge SYS_CLK_I);
        check(REQ_READY_O, 0);
        wait_ready();
        check(CFG_O, CFG_I);
        check({IRQ_RAW_STATUS_O.wait_rise, MEM_DATA_O}, 17'h15A3C);
    endtask : t_smrst
    // main sequence
    initial begin
        t_reset();
        t_nand();
        t_park();
        t_ext();
        t_sr();
        t_smrst();
        end_sim();
    end
endmodule : tb_async_wait_bus_park
